// >>> core/acqd_top.v
// acquisition path: source select, down-conversion, gate-driven dma packetizer, playback strip
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`include "acqd_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// Function
// - source: converter 0, 1 or test
// - gate end closes gate-driven transfer
// - metadata: channel id, timestamp, length
// - one 32-bit tuning word shared by all sources
// - decimation factor 2 to 65535
// - loadable 24-bit filter coefficients
// - default coefficients: flat, all taps equal
// - output fs/N, 8+24 (top 8 of i, 24 of q) or 16+16
// - signal packets: sid, seconds, fraction, trailer
// - timestamps from metadata engine only
// - seconds count up on one_second_pulse
// - fraction on divided clock, pulse clears
// - playback strips header, sid, time, trailer
// - interpolator 2x to 65535x on output
module acqd_top #(
	parameter NTAPS = 8,
	parameter FIFO_DEPTH = 16
) (
	// clock and reset
	input wire clk_sys_i,
	input wire reset_i,
	// converter, gate and one-second pulse inputs
	input wire [15:0] conv0_data_i,
	input wire [15:0] conv1_data_i,
	input wire gate_i,
	input wire one_second_pulse_i,
	// axi4-lite write channels
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read channels
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// packet stream toward host memory
	output reg pkt_valid_o,
	output reg [31:0] pkt_data_o,
	output reg pkt_last_o,
	input wire pkt_ready_i,
	// playback stream in from host and samples out
	input wire play_valid_i,
	input wire [31:0] play_data_i,
	input wire play_last_i,
	output reg play_ready_o,
	output reg out_valid_o,
	output reg [15:0] out_data_o
);
	////////////////////////////////////////////////////////////////////////////
	// register file
	reg [5:0] ctrl_r; // source, gate mode, format, enable, seconds count on pulse
	reg [31:0] tune_r; // local oscillator tuning word
	reg [15:0] decim_r; // decimation factor
	reg [15:0] pkt_len_r; // payload words per packet
	reg [31:0] sid_r; // stream identifier
	reg [31:0] trl_r; // trailer word
	reg [31:0] desc_r; // sample length of each fixed length link
	reg [31:0] sec_init_r; // seconds preload value
	reg [23:0] coef_r [0:NTAPS-1]; // filter coefficients
	reg [31:0] meta_len_r; // last recorded transfer length
	reg [15:0] link_idx_r; // current descriptor index
	reg [31:0] sec_r; // integer seconds
	reg [31:0] frac_r; // fractional seconds
	reg [7:0] frac_div_r; // clock divider for fraction
	reg [7:0] aw_addr_r; // latched write address
	reg aw_have_r; // write address held
	reg [31:0] w_data_r; // latched write data
	reg w_have_r; // write data held
	reg capt_r; // capture window open
	wire w_fire; // write commits this cycle
	wire r_stat_rd; // status read clears overflow
	integer i;
	////////////////////////////////////////////////////////////////////////////
	// input synchronisers: pins pass two flops before any logic
	reg [2:0] gate_s_r; // [0] first stage, [1] second, [2] edge history
	reg [2:0] pps_s_r;
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			gate_s_r <= 3'h0;
			pps_s_r <= 3'h0;
		end else begin
			gate_s_r <= {gate_s_r[1:0], gate_i};
			pps_s_r <= {pps_s_r[1:0], one_second_pulse_i};
		end
	end
	wire gate_lv = gate_s_r[1];
	wire gate_fall = gate_s_r[2] & ~gate_s_r[1];
	wire gate_rise = ~gate_s_r[2] & gate_s_r[1];
	wire pps_rise = ~pps_s_r[2] & pps_s_r[1];
	// converter words treated as pin inputs too
	reg [15:0] c0_a_r, c0_b_r, c1_a_r, c1_b_r;
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			c0_a_r <= 16'h0000;
			c0_b_r <= 16'h0000;
			c1_a_r <= 16'h0000;
			c1_b_r <= 16'h0000;
		end else begin
			c0_a_r <= conv0_data_i;
			c0_b_r <= c0_a_r;
			c1_a_r <= conv1_data_i;
			c1_b_r <= c1_a_r;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// timestamp counters
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			sec_r <= 32'h00000000;
			frac_r <= 32'h00000000;
			frac_div_r <= 8'h00;
		end else begin
			if (w_fire && aw_addr_r == `ACQD_SEC_OFS)
				sec_r <= w_data_r;
			else if (pps_rise && ctrl_r[`ACQD_CTRL_SECINIT_BIT])
				sec_r <= sec_r + 32'h00000001;
			if (pps_rise) begin
				frac_r <= 32'h00000000;
				frac_div_r <= 8'h00;
			end else if (frac_div_r == `ACQD_FRAC_DIV - 8'h01) begin
				frac_div_r <= 8'h00;
				frac_r <= frac_r + 32'h00000001;
			end else
				frac_div_r <= frac_div_r + 8'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// source select, mixer and decimating filter
	reg [15:0] test_r; // test ramp generator
	reg [15:0] src_r; // selected sample
	reg [31:0] phase_r; // oscillator phase
	reg [15:0] dcnt_r; // decimation counter
	reg [47:0] acc_i_r, acc_q_r; // filter accumulators
	reg [2:0] tap_r; // coefficient index
	reg samp_v_r; // decimated sample strobe
	reg [47:0] samp_r; // 24-bit i + 24-bit q
	wire signed [16:0] lo_i = phase_r[31] ? -17'sd16384 : 17'sd16384; // square oscillator
	wire signed [16:0] lo_q = phase_r[30] ? -17'sd16384 : 17'sd16384;
	wire signed [23:0] cf = coef_r[tap_r];
	wire signed [33:0] mix_i = $signed({src_r[15], src_r}) * lo_i;
	wire signed [33:0] mix_q = $signed({src_r[15], src_r}) * lo_q;
	wire signed [47:0] prod_i = $signed(mix_i[33:14]) * cf;
	wire signed [47:0] prod_q = $signed(mix_q[33:14]) * cf;
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			test_r <= 16'h0000;
			src_r <= 16'h0000;
			phase_r <= 32'h00000000;
			dcnt_r <= 16'h0000;
			acc_i_r <= 48'h000000000000;
			acc_q_r <= 48'h000000000000;
			tap_r <= 3'h0;
			samp_v_r <= 1'b0;
			samp_r <= 48'h000000000000;
		end else begin
			test_r <= test_r + 16'h0101;
			case (ctrl_r[1:0])
				`ACQD_SRC_CONV0: src_r <= c0_b_r;
				`ACQD_SRC_CONV1: src_r <= c1_b_r;
				default: src_r <= test_r;
			endcase
			phase_r <= phase_r + tune_r;
			tap_r <= tap_r + 3'h1;
			samp_v_r <= 1'b0;
			if (dcnt_r >= decim_r - 16'h0001) begin
				dcnt_r <= 16'h0000;
				samp_v_r <= 1'b1;
				samp_r <= {acc_i_r[47:24], acc_q_r[47:24]};
				acc_i_r <= prod_i;
				acc_q_r <= prod_q;
			end else begin
				dcnt_r <= dcnt_r + 16'h0001;
				acc_i_r <= acc_i_r + prod_i;
				acc_q_r <= acc_q_r + prod_q;
			end
		end
	end
	wire [31:0] samp_word = ctrl_r[`ACQD_CTRL_FMT16_BIT] ?
		{samp_r[47:32], samp_r[23:8]} : {samp_r[47:40], samp_r[23:0]};
	////////////////////////////////////////////////////////////////////////////
	// sample fifo in the data path
	wire fifo_in_rdy, fifo_out_v;
	wire [31:0] fifo_out_d;
	reg fifo_pop;
	acqd_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.in_valid_i(samp_v_r && capt_r),
		.in_ready_o(fifo_in_rdy),
		.in_data_i(samp_word),
		.out_valid_o(fifo_out_v),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_out_d)
	);
	////////////////////////////////////////////////////////////////////////////
	// dma packetizer state machine
	localparam ST_IDLE = 3'h0;
	localparam ST_HDR = 3'h1;
	localparam ST_SID = 3'h2;
	localparam ST_SEC = 3'h3;
	localparam ST_FRAC = 3'h4;
	localparam ST_DATA = 3'h5;
	localparam ST_TRL = 3'h6;
	localparam ST_META = 3'h7;
	reg [2:0] st_r;
	reg gate_end_r; // gate closed, flush pending
	reg [15:0] wcnt_r; // words in packet
	reg [31:0] xfer_r; // samples moved this transfer
	reg [31:0] ts_sec_r, ts_frac_r; // latched metadata timestamp
	reg ovf_r; // sample lost to full fifo
	wire gmode = ctrl_r[`ACQD_CTRL_GATE_BIT];
	wire out_free = !pkt_valid_o || pkt_ready_i;
	always @* begin
		fifo_pop = (st_r == ST_DATA) && out_free && fifo_out_v;
	end
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			st_r <= ST_IDLE;
			capt_r <= 1'b0;
			gate_end_r <= 1'b0;
			wcnt_r <= 16'h0000;
			xfer_r <= 32'h00000000;
			ts_sec_r <= 32'h00000000;
			ts_frac_r <= 32'h00000000;
			meta_len_r <= 32'h00000000;
			link_idx_r <= 16'h0000;
			ovf_r <= 1'b0;
			pkt_valid_o <= 1'b0;
			pkt_data_o <= 32'h00000000;
			pkt_last_o <= 1'b0;
		end else begin
			if (pkt_valid_o && pkt_ready_i)
				pkt_valid_o <= 1'b0;
			if (samp_v_r && capt_r && !fifo_in_rdy)
				ovf_r <= 1'b1;
			if (r_stat_rd)
				ovf_r <= samp_v_r && capt_r && !fifo_in_rdy;
			if (gmode && gate_fall && capt_r) begin
				capt_r <= 1'b0;
				gate_end_r <= 1'b1;
			end
			if (!ctrl_r[`ACQD_CTRL_EN_BIT])
				capt_r <= 1'b0;
			case (st_r)
				ST_IDLE: begin
					if (ctrl_r[`ACQD_CTRL_EN_BIT] && (!gmode || gate_rise)) begin
						capt_r <= 1'b1;
						xfer_r <= 32'h00000000;
						ts_sec_r <= sec_r;
						ts_frac_r <= frac_r;
						st_r <= ST_HDR;
					end
				end
				ST_HDR: if (out_free) begin
					pkt_valid_o <= 1'b1;
					pkt_last_o <= 1'b0;
					pkt_data_o <= {`ACQD_HDR_TYPE, 12'h000, pkt_len_r + `ACQD_PKT_OVH};
					wcnt_r <= 16'h0000;
					st_r <= ST_SID;
				end
				ST_SID: if (out_free) begin
					pkt_valid_o <= 1'b1;
					pkt_data_o <= sid_r;
					st_r <= ST_SEC;
				end
				ST_SEC: if (out_free) begin
					pkt_valid_o <= 1'b1;
					pkt_data_o <= ts_sec_r;
					st_r <= ST_FRAC;
				end
				ST_FRAC: if (out_free) begin
					pkt_valid_o <= 1'b1;
					pkt_data_o <= ts_frac_r;
					st_r <= ST_DATA;
				end
				ST_DATA: begin
					if (fifo_pop) begin
						pkt_valid_o <= 1'b1;
						pkt_data_o <= fifo_out_d;
						wcnt_r <= wcnt_r + 16'h0001;
						xfer_r <= xfer_r + 32'h00000001;
						if (wcnt_r + 16'h0001 >= pkt_len_r)
							st_r <= ST_TRL;
					end else if (gate_end_r && !fifo_out_v && out_free)
						st_r <= ST_TRL;
				end
				ST_TRL: if (out_free) begin
					pkt_valid_o <= 1'b1;
					pkt_data_o <= trl_r;
					pkt_last_o <= 1'b1;
					if (gate_end_r || (!gmode && xfer_r >= desc_r))
						st_r <= ST_META;
					else
						st_r <= ST_HDR;
				end
				ST_META: if (out_free) begin
					pkt_valid_o <= 1'b1;
					pkt_data_o <= {14'h0000, ctrl_r[1:0], link_idx_r};
					pkt_last_o <= 1'b1;
					meta_len_r <= xfer_r;
					link_idx_r <= link_idx_r + 16'h0001;
					gate_end_r <= 1'b0;
					capt_r <= 1'b0;
					st_r <= ST_IDLE;
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// playback path: strip five overhead words, keep samples
	reg [2:0] play_pos_r; // word position within packet
	reg [15:0] hold_r; // interpolation hold counter
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			play_pos_r <= 3'h0;
			hold_r <= 16'h0000;
			play_ready_o <= 1'b0;
			out_valid_o <= 1'b0;
			out_data_o <= 16'h0000;
		end else begin
			out_valid_o <= 1'b0;
			play_ready_o <= (hold_r == 16'h0000) && !(play_valid_i && play_ready_o);
			if (hold_r != 16'h0000)
				hold_r <= hold_r - 16'h0001;
			if (play_valid_i && play_ready_o) begin
				play_pos_r <= play_last_i ? 3'h0 :
					(play_pos_r == 3'h4 ? 3'h4 : play_pos_r + 3'h1);
				if (play_pos_r == 3'h4 && !play_last_i) begin
					out_valid_o <= 1'b1;
					out_data_o <= play_data_i[15:0];
					hold_r <= decim_r - 16'h0001;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave
	assign w_fire = aw_have_r && w_have_r && !s_axi_bvalid;
	assign r_stat_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == `ACQD_STAT_OFS;
	function [31:0] strb_merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] st;
		begin
			strb_merge = {st[3] ? nw[31:24] : old[31:24], st[2] ? nw[23:16] : old[23:16],
				st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
		end
	endfunction
	reg [3:0] w_strb_r; // latched strobes
	wire [31:0] dec_w = strb_merge({16'h0000, decim_r}, w_data_r, w_strb_r);
	// write channel handling
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			ctrl_r <= 6'h00;
			tune_r <= 32'h00000000;
			decim_r <= `ACQD_DECIM_RST;
			pkt_len_r <= `ACQD_PKT_RST;
			sid_r <= 32'h00000000;
			trl_r <= 32'h00000000;
			desc_r <= 32'h00000100;
			sec_init_r <= 32'h00000000;
			// default coefficient set, flat unity taps
			for (i = 0; i < NTAPS; i = i + 1)
				coef_r[i] <= 24'h100000;
		end else begin
			s_axi_awready <= !aw_have_r && !s_axi_awready;
			s_axi_wready <= !w_have_r && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (w_fire) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				if (aw_addr_r == `ACQD_CTRL_OFS)
					ctrl_r <= w_data_r[5:0];
				else if (aw_addr_r == `ACQD_TUNE_OFS)
					tune_r <= strb_merge(tune_r, w_data_r, w_strb_r);
				else if (aw_addr_r == `ACQD_DECIM_OFS)
					decim_r <= (dec_w[15:0] < `ACQD_DECIM_MIN) ? `ACQD_DECIM_MIN : dec_w[15:0];
				// coefficient load, tap index in bits 26:24 above the coefficient
				else if (aw_addr_r == `ACQD_COEF_OFS)
					coef_r[w_data_r[26:24]] <= w_data_r[23:0];
				else if (aw_addr_r == `ACQD_PKT_OFS)
					pkt_len_r <= (w_data_r[15:0] == 16'h0000) ? 16'h0001 : w_data_r[15:0];
				else if (aw_addr_r == `ACQD_SID_OFS)
					sid_r <= w_data_r;
				else if (aw_addr_r == `ACQD_TRL_OFS)
					trl_r <= w_data_r;
				else if (aw_addr_r == `ACQD_DESC_OFS)
					desc_r <= w_data_r;
				else if (aw_addr_r == `ACQD_SEC_OFS)
					sec_init_r <= w_data_r;
				else
					s_axi_bresp <= 2'h2;
			end
		end
	end
	// read channel: one cycle after address accepted
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
				(!s_axi_rvalid && !s_axi_arready);
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				if (s_axi_araddr == `ACQD_CTRL_OFS)
					s_axi_rdata <= {26'h0000000, ctrl_r};
				else if (s_axi_araddr == `ACQD_TUNE_OFS)
					s_axi_rdata <= tune_r;
				else if (s_axi_araddr == `ACQD_DECIM_OFS)
					s_axi_rdata <= {16'h0000, decim_r};
				else if (s_axi_araddr == `ACQD_PKT_OFS)
					s_axi_rdata <= {16'h0000, pkt_len_r};
				else if (s_axi_araddr == `ACQD_SID_OFS)
					s_axi_rdata <= sid_r;
				else if (s_axi_araddr == `ACQD_TRL_OFS)
					s_axi_rdata <= trl_r;
				else if (s_axi_araddr == `ACQD_DESC_OFS)
					s_axi_rdata <= desc_r;
				else if (s_axi_araddr == `ACQD_SEC_OFS)
					s_axi_rdata <= sec_r;
				else if (s_axi_araddr == `ACQD_STAT_OFS)
					s_axi_rdata <= {ovf_r, capt_r, gate_lv, 10'h000, st_r, link_idx_r};
				else if (s_axi_araddr == `ACQD_META_OFS)
					s_axi_rdata <= meta_len_r;
				else if (s_axi_araddr == `ACQD_COEF_OFS)
					s_axi_rdata <= {8'h00, coef_r[0]};
				else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			end
		end
	end
endmodule

// >>> core/acqd_regs.vh
// register map, field layout and timing constants of the acquisition packetizer
`ifndef ACQD_REGS_VH
`define ACQD_REGS_VH
// register byte offsets
`define ACQD_CTRL_OFS 8'h00
`define ACQD_TUNE_OFS 8'h04
`define ACQD_DECIM_OFS 8'h08
`define ACQD_COEF_OFS 8'h0C
`define ACQD_PKT_OFS 8'h10
`define ACQD_SID_OFS 8'h14
`define ACQD_TRL_OFS 8'h18
`define ACQD_DESC_OFS 8'h1C
`define ACQD_SEC_OFS 8'h20
`define ACQD_STAT_OFS 8'h24
`define ACQD_META_OFS 8'h28
// control fields
`define ACQD_CTRL_SRC_LSB 0
`define ACQD_CTRL_GATE_BIT 2
`define ACQD_CTRL_FMT16_BIT 3
`define ACQD_CTRL_EN_BIT 4
`define ACQD_CTRL_SECINIT_BIT 5
// input source codes
`define ACQD_SRC_CONV0 2'h0
`define ACQD_SRC_CONV1 2'h1
`define ACQD_SRC_TEST 2'h2
// reset values and decimation lower limit
`define ACQD_DECIM_RST 16'h0002
`define ACQD_PKT_RST 16'h0010
`define ACQD_DECIM_MIN 16'h0002
// fractional counter clock division
`define ACQD_FRAC_DIV 8'h04
// packet header word (signal data type in the top nibble)
`define ACQD_HDR_TYPE 4'h1
`define ACQD_PKT_OVH 16'h0005
`endif

// >>> core/acqd_fifo.v
// parameterised first-word-fall-through fifo with valid/ready on both sides
`timescale 1ns/10ps
module acqd_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// clock and reset
	input wire clk_sys_i,
	input wire reset_i,
	// fill side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	// drain side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
	reg [AW-1:0] wr_r; // write pointer
	reg [AW-1:0] rd_r; // read pointer
	reg [AW:0] cnt_r; // occupancy
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	assign in_ready_o = (cnt_r != DEPTH);
	assign out_valid_o = (cnt_r != 0);
	assign out_data_o = mem[rd_r];
	// pointer and occupancy update
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			wr_r <= {AW{1'b0}};
			rd_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem[wr_r] <= in_data_i;
				wr_r <= wr_r + 1'b1;
			end
			if (pop)
				rd_r <= rd_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

// >>> verification/acqd_chk_sva.sv
// port checker of the acquisition packetizer
`timescale 1ns/10ps
module acqd_chk (
	// clock and reset
	input wire clk_sys_i,
	input wire reset_i,
	// axi answers
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	// streams
	input wire pkt_valid_o,
	input wire pkt_ready_i,
	input wire [31:0] pkt_data_o,
	input wire pkt_last_o,
	input wire out_valid_o,
	input wire play_ready_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);
	////////////////////////////////////////////////////////////////////////////////
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
		else $error("bad write response");
	// a stalled word must not move under the host
	a_pkt_hold: assert property (pkt_valid_o && !pkt_ready_i |=>
		pkt_valid_o && $stable(pkt_data_o) && $stable(pkt_last_o))
		else $error("packet word changed while stalled");
	a_out_pulse: assert property (out_valid_o |=> !out_valid_o)
		else $error("sample strobe too long");
	a_interp_hold: assert property (out_valid_o |=> !play_ready_o)
		else $error("no interpolation hold");
	a_reset_quiet: assert property ($fell(reset_i) |->
		!pkt_valid_o && !out_valid_o && !s_axi_bvalid && !s_axi_rvalid)
		else $error("output busy after reset");
	c_pkt_end: cover property (pkt_valid_o && pkt_ready_i && pkt_last_o);
	c_sample: cover property (out_valid_o);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

// >>> verification/acqd_host_mem.sv
// host memory model: packet sink with stalls, playback packet source
`timescale 1ns/10ps
module acqd_host_mem (
	// clock and reset
	input wire clk_sys_i,
	input wire reset_i,
	// packet sink
	output logic pkt_ready_o,
	// playback source
	input wire play_ready_i,
	output logic play_valid_o,
	output logic [31:0] play_data_o,
	output logic play_last_o
);
	bit slow = 1'b0; // bench sets this for random stalls
	initial begin
		pkt_ready_o = 1'b0;
		play_valid_o = 1'b0;
		play_data_o = 32'h0;
		play_last_o = 1'b0;
	end
	// ready drops at random while slow, so the packet word hold is exercised
	always @(posedge clk_sys_i) begin
		if (reset_i)
			pkt_ready_o <= 1'b0;
		else
			pkt_ready_o <= !slow || ($urandom % 3 != 0);
	end
	////////////////////////////////////////////////////////////////////////////////
	// four header words, samples, trailer
	task automatic send_play(input logic [15:0] base, input int n);
		logic [31:0] w;
		int k;
		for (int i = 0; i < n + 5; i++) begin
			w = (i < 4 || i == n + 4) ? $urandom : {base + 16'(i - 4), base + 16'(i - 4)};
			play_valid_o <= 1'b1;
			play_data_o <= w;
			play_last_o <= (i == n + 4);
			k = 0;
			do begin
				@(posedge clk_sys_i);
				k++;
			end while (!play_ready_i && k < 200);
		end
		// released bus shows garbage, not the last word
		play_valid_o <= 1'b0;
		play_data_o <= ~w;
		play_last_o <= 1'b0;
	endtask
endmodule

// >>> verification/tb.sv
// self-checking bench of the acquisition packetizer
`timescale 1ns/10ps
`include "acqd_regs.vh"
bind acqd_top acqd_chk u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .pkt_valid_o(pkt_valid_o),
	.pkt_ready_i(pkt_ready_i), .pkt_data_o(pkt_data_o), .pkt_last_o(pkt_last_o),
	.out_valid_o(out_valid_o), .play_ready_o(play_ready_o));
module tb;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] f;} acqd_exp_t;
	logic clk_sys_i = 1'b0, reset_i = 1'b1, gate_i = 1'b0, one_second_pulse_i = 1'b0;
	logic [15:0] conv0_data_i = 16'h0, conv1_data_i = 16'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, sid, trl;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, pkt_data_o, play_data_i;
	logic pkt_valid_o, pkt_last_o, pkt_ready_i, play_valid_i, play_last_i, play_ready_o;
	logic out_valid_o;
	logic [15:0] out_data_o;
	acqd_exp_t rq[$], pq[$], em;
	logic [1:0] bq[$];
	logic [15:0] oq[$];
	int failures = 0, num_checks = 0, n;
	always #20 clk_sys_i = ~clk_sys_i;
	acqd_top dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .conv0_data_i(conv0_data_i),
		.conv1_data_i(conv1_data_i), .gate_i(gate_i), .one_second_pulse_i(one_second_pulse_i),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pkt_valid_o(pkt_valid_o),
		.pkt_data_o(pkt_data_o), .pkt_last_o(pkt_last_o), .pkt_ready_i(pkt_ready_i),
		.play_valid_i(play_valid_i), .play_data_i(play_data_i), .play_last_i(play_last_i),
		.play_ready_o(play_ready_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o));
	acqd_host_mem u_host (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pkt_ready_o(pkt_ready_i),
		.play_ready_i(play_ready_o), .play_valid_o(play_valid_i), .play_data_o(play_data_i),
		.play_last_o(play_last_i));
	////////////////////////////////////////////////////////////////////////////////
	task summarize;
		if (failures == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// a used-up wait ends the run at once
	task tmo(input int k, input int lim);
		if (k >= lim) begin
			chk("wait", 32'h0, 32'h1);
			summarize;
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int k;
		@(posedge clk_sys_i);
		k = 0;
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			k++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready) && k < 100);
		s_axi_bready <= 1'b0;
		tmo(k, 100);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] r);
		acqd_exp_t e;
		int k;
		@(posedge clk_sys_i);
		k = 0;
		e = '{d, m, r};
		rq.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			k++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready) && k < 100);
		s_axi_rready <= 1'b0;
		tmo(k, 100);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// converters run free with random samples
	always @(posedge clk_sys_i) begin
		conv0_data_i <= 16'($urandom);
		conv1_data_i <= 16'($urandom);
	end
	// each result takes the oldest note of its kind
	always @(posedge clk_sys_i) begin
		if (s_axi_rvalid && s_axi_rready) begin
			em = (rq.size() > 0) ? rq.pop_front() : acqd_exp_t'{32'h0, 32'h0, 2'h3};
			chk("rdata", em.d & em.m, s_axi_rdata & em.m);
			chk("rresp", {30'h0, em.f}, {30'h0, s_axi_rresp});
		end
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", {30'h0, (bq.size() > 0) ? bq.pop_front() : 2'h3}, {30'h0, s_axi_bresp});
		if (pkt_valid_o && pkt_ready_i) begin
			em = (pq.size() > 0) ? pq.pop_front() : acqd_exp_t'{32'h0, 32'h0, 2'h3};
			chk("pkt_data", em.d & em.m, pkt_data_o & em.m);
			chk("pkt_last", {30'h0, em.f}, {31'h0, pkt_last_o});
		end
		if (out_valid_o)
			chk("out_data", {16'h0, (oq.size() > 0) ? oq.pop_front() : ~out_data_o}, {16'h0, out_data_o});
	end
	initial begin
		void'($urandom(32'h5C89));
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		axr(`ACQD_DECIM_OFS, {16'h0, `ACQD_DECIM_RST}, 32'hFFFF, 2'h0);
		axr(`ACQD_PKT_OFS, {16'h0, `ACQD_PKT_RST}, 32'hFFFF, 2'h0);
		sid = $urandom;
		axw(`ACQD_TUNE_OFS, sid, 2'h0);
		axr(`ACQD_TUNE_OFS, sid, 32'hFFFFFFFF, 2'h0);
		// unmapped place answers with slave error
		axw(8'hFC, 32'h0, 2'h2);
		axr(8'hFC, 32'h0, 32'h0, 2'h2);
		// decimation at 32768 and below its lower end
		for (int j = 0; j < 2; j++) begin
			axw(`ACQD_DECIM_OFS, 32'h8000 >> (j * 15), 2'h0);
			axr(`ACQD_DECIM_OFS, j ? `ACQD_DECIM_MIN : 32'h8000, 32'hFFFF, 2'h0);
		end
		for (int s = 0; s < 3; s++) begin
			axw(`ACQD_CTRL_OFS, s, 2'h0);
			axr(`ACQD_CTRL_OFS, s, 32'h3, 2'h0);
		end
		// seconds preset then three pulses
		axw(`ACQD_CTRL_OFS, 32'h20, 2'h0);
		axw(`ACQD_SEC_OFS, 32'h5, 2'h0);
		repeat (3) begin
			repeat (4) @(posedge clk_sys_i) one_second_pulse_i <= 1'b1;
			repeat (4) @(posedge clk_sys_i) one_second_pulse_i <= 1'b0;
		end
		axr(`ACQD_SEC_OFS, 32'h8, 32'hFFFFFFFF, 2'h0);
		// gate-driven packet of four test samples under host stalls
		sid = $urandom;
		trl = $urandom;
		axw(`ACQD_PKT_OFS, 32'h10, 2'h0);
		axw(`ACQD_SID_OFS, sid, 2'h0);
		axw(`ACQD_TRL_OFS, trl, 2'h0);
		axw(`ACQD_DESC_OFS, 32'h2, 2'h0);
		pq = '{'{{`ACQD_HDR_TYPE, 28'h15}, 32'hF000FFFF, 2'h0}, '{sid, 32'hFFFFFFFF, 2'h0},
			'{32'h8, 32'hFFFFFFFF, 2'h0}, '{32'h0, 32'h0, 2'h0}, '{32'h0, 32'h0, 2'h0},
			'{32'h0, 32'h0, 2'h0}, '{32'h0, 32'h0, 2'h0}, '{32'h0, 32'h0, 2'h0},
			'{trl, 32'hFFFFFFFF, 2'h1}, '{32'h20000, 32'hFFFFFFFF, 2'h1}};
		u_host.slow = 1'b1;
		axw(`ACQD_CTRL_OFS, 32'h3E, 2'h0);
		@(posedge clk_sys_i) gate_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		gate_i <= 1'b0;
		oq = '{16'h1234, 16'h1235, 16'h1236};
		u_host.send_play(16'h1234, 3);
		n = 0;
		while ((pq.size() > 0 || oq.size() > 0) && n < 3000) begin
			@(posedge clk_sys_i);
			n++;
		end
		tmo(n, 3000);
		axr(`ACQD_META_OFS, 32'h4, 32'hFFFF, 2'h0);
		summarize;
	end
endmodule
